// ---- rps_defs.vh ----
// Purpose: constants for the remappable output pin select block
// Assumes: included by every design file of the block
// Notes:   one pair of selector fields per map register
`ifndef RPS_DEFS_VH
`define RPS_DEFS_VH
// ------------------------------------------------------------
// sizes
// ------------------------------------------------------------
`define RPS_SEL_W        5
`define RPS_NUM_PINS     26
`define RPS_NUM_OUT_REGS 13
`define RPS_NUM_IN_FLDS  16
`define RPS_NUM_IN_REGS  8
`define RPS_SRC_W        23
// ------------------------------------------------------------
// field layout and reset values
// ------------------------------------------------------------
`define RPS_FLD0_LSB     0
`define RPS_FLD1_LSB     8
`define RPS_OUT_RESET    5'h00
`define RPS_IN_RESET     5'h1f
// ------------------------------------------------------------
// write targets
// ------------------------------------------------------------
`define RPS_TGT_OSC      2'h0
`define RPS_TGT_OUT      2'h1
`define RPS_TGT_IN       2'h2
// ------------------------------------------------------------
// lock key
// ------------------------------------------------------------
`define RPS_KEY_FIRST    8'h46
`define RPS_KEY_SECOND   8'h57
`define RPS_LOCK_BIT     6
// ------------------------------------------------------------
// output function codes
// ------------------------------------------------------------
`define RPS_CODE_NULL    5'h00
`define RPS_CODE_CMP_A   5'h01
`define RPS_CODE_SPI_LO  5'h0c
`define RPS_CODE_OC_LO   5'h12
`define RPS_CODE_OC_HI   5'h16
`endif

// ---- rps_out_sel.v ----
// Purpose: one pin's output selector
// Assumes: src bit n carries the peripheral output of function code n
// Notes:   purely combinational, registered by the caller
`timescale 1ns/1ns
`include "rps_defs.vh"
module rps_out_sel (
   input  wire [`RPS_SEL_W-1:0] sel,
   input  wire [`RPS_SRC_W-1:0] src,
   output wire                  drive,
   output wire                  active
);
   // ------------------------------------------------------------
   // code decode
   // ------------------------------------------------------------
   function is_listed;
      input [`RPS_SEL_W-1:0] code;
      begin
         is_listed = ((code >= `RPS_CODE_CMP_A) && (code <= `RPS_CODE_SPI_LO)) ||
                     ((code >= `RPS_CODE_OC_LO) && (code <= `RPS_CODE_OC_HI));
      end
   endfunction

   assign active = is_listed(sel); // (RULE2) (RULE6)
   // one code per pin, so two outputs can never meet on a pin
   assign drive  = active & src[sel]; // (RULE1) (RULE8)
endmodule

// ---- rps_periph_model.sv ----
// Purpose: peripheral outputs and pad levels facing the pin map
// Assumes: bench chooses the wanted levels
// Notes:   levels launch on the clock edge, as registered peripherals do
`timescale 1ns/1ns
module rps_periph_model (
   input  wire        clk,
   input  wire        nrst,
   input  wire [17:0] want_src,
   input  wire [25:0] want_pin,
   output reg  [17:0] src,
   output reg  [25:0] pin
);
   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         src <= 18'h00000;
         pin <= 26'h0000000;
      end else begin
         src <= want_src;
         pin <= want_pin;
      end
   end
endmodule

// ---- rps_pin_map.v ----
// Purpose: remappable pin output select, input map, lock and shadow monitor
// Assumes: software writes arrive as single-cycle strobes on CORE_CLK
// Notes:   pins and the one-way option come from outside, so they are synchronised
`timescale 1ns/1ns
`include "rps_defs.vh"

// Contract
// (RULE1) each pin has a 5-bit output selector, two fields per map register
// (RULE2) selector zero leaves the pin undriven and its remap output off
// (RULE3) codes 1-6 route comparators a,b and uart a,b tx and rts
// (RULE4) codes 7-12 route spi a then spi b data, clock, select
// (RULE5) codes 18-22 route compare outputs 1 to 5
// (RULE6) unlisted codes act like the null choice
// (RULE7) all output selectors reset to null
// (RULE8) no pin contention on inputs or outputs, no other lockout
// (RULE9) one pin may feed many inputs, one output many pins
// (RULE10) map writes while locked complete but change nothing
// (RULE11) map lock is bit 6 of the oscillator control register
// (RULE12) software writes 46h then 57h, then lock change in one write
// (RULE13) lock write not right after both keys leaves lock unchanged
// (RULE14) lock keeps its value until the next valid key sequence
// (RULE15) shadow copies of map registers raise a mismatch reset on difference
// (RULE16) with one-way option, a set lock cannot be cleared until reset
// (RULE17) map lock resets cleared
// (RULE18) input selectors reset to all ones, pin 31
module rps_pin_map (
   input  wire                        CORE_CLK,
   input  wire                        NRST,
   input  wire                        WR_STROBE,
   input  wire [1:0]                  WR_TARGET,
   input  wire [3:0]                  WR_INDEX,
   input  wire [15:0]                 WR_DATA,
   input  wire                        ONE_WAY_LOCK_OPTION,
   input  wire [`RPS_NUM_PINS-1:0]    PIN_IN,
   input  wire                        COMPARATOR_A_OUT,
   input  wire                        COMPARATOR_B_OUT,
   input  wire                        UART_A_TX,
   input  wire                        UART_A_RTS,
   input  wire                        UART_B_TX,
   input  wire                        UART_B_RTS,
   input  wire                        SPI_A_DATA_OUT,
   input  wire                        SPI_A_CLOCK_OUT,
   input  wire                        SPI_A_SELECT_OUT,
   input  wire                        SPI_B_DATA_OUT,
   input  wire                        SPI_B_CLOCK_OUT,
   input  wire                        SPI_B_SELECT_OUT,
   input  wire                        COMPARE_OUT_1,
   input  wire                        COMPARE_OUT_2,
   input  wire                        COMPARE_OUT_3,
   input  wire                        COMPARE_OUT_4,
   input  wire                        COMPARE_OUT_5,
   output reg  [`RPS_NUM_PINS-1:0]    PIN_OUT,
   output reg  [`RPS_NUM_PINS-1:0]    PIN_OE_N,
   output reg  [`RPS_NUM_IN_FLDS-1:0] PERIPH_IN,
   output reg                         MAP_LOCK,
   output reg                         MISMATCH_RESET
);
   // ------------------------------------------------------------
   // key sequence states
   // ------------------------------------------------------------
   localparam [1:0] KEY_IDLE  = 2'h0;
   localparam [1:0] KEY_FIRST = 2'h1;
   localparam [1:0] KEY_READY = 2'h2;

   reg  [`RPS_SEL_W-1:0]      out_sel    [0:`RPS_NUM_PINS-1];
   reg  [`RPS_SEL_W-1:0]      out_shadow [0:`RPS_NUM_PINS-1];
   reg  [`RPS_SEL_W-1:0]      in_sel     [0:`RPS_NUM_IN_FLDS-1];
   reg  [`RPS_SEL_W-1:0]      in_shadow  [0:`RPS_NUM_IN_FLDS-1];
   reg  [1:0]                 key_state;
   reg  [1:0]                 next_key_state;
   reg                        next_lock;
   reg                        one_way_meta;
   reg                        one_way;
   reg  [`RPS_NUM_PINS-1:0]   pin_meta;
   reg  [`RPS_NUM_PINS-1:0]   pin_sync;
   reg                        next_mismatch;
   reg  [`RPS_NUM_IN_FLDS-1:0] next_periph_in;
   wire [`RPS_SRC_W-1:0]      src;
   wire [`RPS_NUM_PINS-1:0]   pin_drive;
   wire [`RPS_NUM_PINS-1:0]   pin_active;
   wire [7:0]                 osc_low;
   wire                       osc_wr;
   wire                       map_wr_ok;
   integer                    i;
   // own loop index, so the combinational process shares no variable
   integer                    k;

   assign osc_low   = WR_DATA[7:0];
   assign osc_wr    = WR_STROBE && (WR_TARGET == `RPS_TGT_OSC);
   assign map_wr_ok = WR_STROBE && !MAP_LOCK; // (RULE10)

   // ------------------------------------------------------------
   // source vector, bit index equals function code
   // ------------------------------------------------------------
   assign src = {COMPARE_OUT_5, COMPARE_OUT_4, COMPARE_OUT_3, COMPARE_OUT_2,
                 COMPARE_OUT_1, 5'h00,
                 SPI_B_SELECT_OUT, SPI_B_CLOCK_OUT, SPI_B_DATA_OUT,
                 SPI_A_SELECT_OUT, SPI_A_CLOCK_OUT, SPI_A_DATA_OUT,
                 UART_B_RTS, UART_B_TX, UART_A_RTS, UART_A_TX,
                 COMPARATOR_B_OUT, COMPARATOR_A_OUT, 1'b0}; // (RULE3) (RULE4) (RULE5)

   // ------------------------------------------------------------
   // per-pin selectors
   // ------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `RPS_NUM_PINS; g = g + 1) begin : pin
         rps_out_sel u_sel (
            .sel    (out_sel[g]),
            .src    (src),
            .drive  (pin_drive[g]),
            .active (pin_active[g])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // synchronisers
   // ------------------------------------------------------------
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         one_way_meta <= 1'b0;
         one_way      <= 1'b0;
         pin_meta     <= {`RPS_NUM_PINS{1'b0}};
         pin_sync     <= {`RPS_NUM_PINS{1'b0}};
      end else begin
         one_way_meta <= ONE_WAY_LOCK_OPTION;
         one_way      <= one_way_meta;
         pin_meta     <= PIN_IN;
         pin_sync     <= pin_meta;
      end
   end

   // ------------------------------------------------------------
   // key sequence and lock
   // ------------------------------------------------------------
   always @* begin
      next_key_state = key_state;
      next_lock      = MAP_LOCK;
      if (WR_STROBE) begin
         // any other write in between breaks the sequence
         next_key_state = KEY_IDLE;
         if (osc_wr) begin
            case (key_state)
               KEY_IDLE: begin
                  if (osc_low == `RPS_KEY_FIRST)
                     next_key_state = KEY_FIRST; // (RULE12)
               end
               KEY_FIRST: begin
                  if (osc_low == `RPS_KEY_SECOND)
                     next_key_state = KEY_READY; // (RULE12)
                  else if (osc_low == `RPS_KEY_FIRST)
                     next_key_state = KEY_FIRST;
               end
               KEY_READY: begin
                  if (!(one_way && MAP_LOCK))
                     next_lock = osc_low[`RPS_LOCK_BIT]; // (RULE11) (RULE13) (RULE16)
               end
               default: begin
                  next_key_state = KEY_IDLE;
               end
            endcase
         end
      end
   end

   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         key_state <= KEY_IDLE;
         MAP_LOCK  <= 1'b0; // (RULE17)
      end else begin
         key_state <= next_key_state;
         MAP_LOCK  <= next_lock; // (RULE14)
      end
   end

   // ------------------------------------------------------------
   // map registers and shadows
   // ------------------------------------------------------------
   // both copies take the same legal write, so only an upset can split them
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         for (i = 0; i < `RPS_NUM_PINS; i = i + 1) begin
            out_sel[i]    <= `RPS_OUT_RESET; // (RULE7)
            out_shadow[i] <= `RPS_OUT_RESET;
         end
         for (i = 0; i < `RPS_NUM_IN_FLDS; i = i + 1) begin
            in_sel[i]    <= `RPS_IN_RESET; // (RULE18)
            in_shadow[i] <= `RPS_IN_RESET;
         end
      end else if (map_wr_ok) begin
         if ((WR_TARGET == `RPS_TGT_OUT) && (WR_INDEX < `RPS_NUM_OUT_REGS)) begin
            out_sel[{WR_INDEX, 1'b0}] <= WR_DATA[`RPS_FLD0_LSB +: `RPS_SEL_W]; // (RULE1)
            out_sel[{WR_INDEX, 1'b1}] <= WR_DATA[`RPS_FLD1_LSB +: `RPS_SEL_W];
            out_shadow[{WR_INDEX, 1'b0}] <= WR_DATA[`RPS_FLD0_LSB +: `RPS_SEL_W];
            out_shadow[{WR_INDEX, 1'b1}] <= WR_DATA[`RPS_FLD1_LSB +: `RPS_SEL_W];
         end
         if ((WR_TARGET == `RPS_TGT_IN) && (WR_INDEX < `RPS_NUM_IN_REGS)) begin
            in_sel[{WR_INDEX[2:0], 1'b0}] <= WR_DATA[`RPS_FLD0_LSB +: `RPS_SEL_W];
            in_sel[{WR_INDEX[2:0], 1'b1}] <= WR_DATA[`RPS_FLD1_LSB +: `RPS_SEL_W];
            in_shadow[{WR_INDEX[2:0], 1'b0}] <= WR_DATA[`RPS_FLD0_LSB +: `RPS_SEL_W];
            in_shadow[{WR_INDEX[2:0], 1'b1}] <= WR_DATA[`RPS_FLD1_LSB +: `RPS_SEL_W];
         end
      end
   end

   // ------------------------------------------------------------
   // input routing and monitor
   // ------------------------------------------------------------
   always @* begin
      next_mismatch  = 1'b0;
      next_periph_in = {`RPS_NUM_IN_FLDS{1'b0}};
      for (k = 0; k < `RPS_NUM_PINS; k = k + 1) begin
         if (out_sel[k] != out_shadow[k])
            next_mismatch = 1'b1; // (RULE15)
      end
      for (k = 0; k < `RPS_NUM_IN_FLDS; k = k + 1) begin
         if (in_sel[k] != in_shadow[k])
            next_mismatch = 1'b1; // (RULE15)
         // a missing pin, such as 31, reads low
         if (in_sel[k] < `RPS_NUM_PINS)
            next_periph_in[k] = pin_sync[in_sel[k]]; // (RULE8) (RULE9)
      end
   end

   // ------------------------------------------------------------
   // registered outputs
   // ------------------------------------------------------------
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         PIN_OUT        <= {`RPS_NUM_PINS{1'b0}};
         PIN_OE_N       <= {`RPS_NUM_PINS{1'b1}};
         PERIPH_IN      <= {`RPS_NUM_IN_FLDS{1'b0}};
         MISMATCH_RESET <= 1'b0;
      end else begin
         PIN_OUT        <= pin_drive; // (RULE9)
         PIN_OE_N       <= ~pin_active; // (RULE2) (RULE6)
         PERIPH_IN      <= next_periph_in;
         MISMATCH_RESET <= next_mismatch;
      end
   end
endmodule

// ---- rps_pin_map_bench.sv ----
// Purpose: bench for the pin map
// Assumes: writes are one strobe per edge, back to back allowed
// Notes:   sources are held steady during each code check
`timescale 1ns/1ns
module rps_pin_map_bench;
   reg         clk, nrst, wr_strobe, one_way;
   reg  [1:0]  wr_target;
   reg  [3:0]  wr_index;
   reg  [15:0] wr_data;
   reg  [17:0] want_src, pat;
   reg  [25:0] want_pin;
   wire [17:0] src;
   wire [25:0] pin, pin_out, pin_oe_n;
   wire [15:0] periph_in;
   wire        map_lock, mismatch;
   reg  [1:0]  e;
   integer     mismatches, tests_run, c, p;
   always #50 clk = ~clk;
   rps_periph_model model (.clk(clk), .nrst(nrst), .want_src(want_src), .want_pin(want_pin),
      .src(src), .pin(pin));
   rps_pin_map dut (.CORE_CLK(clk), .NRST(nrst), .WR_STROBE(wr_strobe), .WR_TARGET(wr_target),
      .WR_INDEX(wr_index), .WR_DATA(wr_data), .ONE_WAY_LOCK_OPTION(one_way), .PIN_IN(pin),
      .COMPARATOR_A_OUT(src[0]), .COMPARATOR_B_OUT(src[1]), .UART_A_TX(src[2]),
      .UART_A_RTS(src[3]), .UART_B_TX(src[4]), .UART_B_RTS(src[5]), .SPI_A_DATA_OUT(src[6]),
      .SPI_A_CLOCK_OUT(src[7]), .SPI_A_SELECT_OUT(src[8]), .SPI_B_DATA_OUT(src[9]),
      .SPI_B_CLOCK_OUT(src[10]), .SPI_B_SELECT_OUT(src[11]), .COMPARE_OUT_1(src[12]),
      .COMPARE_OUT_2(src[13]), .COMPARE_OUT_3(src[14]), .COMPARE_OUT_4(src[15]),
      .COMPARE_OUT_5(src[16]), .PIN_OUT(pin_out), .PIN_OE_N(pin_oe_n), .PERIPH_IN(periph_in),
      .MAP_LOCK(map_lock), .MISMATCH_RESET(mismatch));
   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task wr(input [1:0] t, input [3:0] x, input [15:0] d);
      begin
         @(posedge clk);
         wr_strobe <= 1'b1;
         wr_target <= t;
         wr_index <= x;
         wr_data <= d;
      end
   endtask
   task idle(input integer n);
      repeat (n) begin
         @(posedge clk);
         wr_strobe <= 1'b0;
      end
   endtask
   task lock_seq(input [7:0] last);
      begin
         wr(2'h0, 4'h0, 16'h0046);
         wr(2'h0, 4'h0, 16'h0057);
         wr(2'h0, 4'h0, {8'h00, last});
         idle(2);
      end
   endtask
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task print_verdict;
      begin
         if (mismatches == 0 && tests_run > 0)
            $display("verification passed");
         else
            $display("verification failed");
         $finish;
      end
   endtask
   // unlisted codes give undriven, hence {oe_n, out} = 2'b10
   function [1:0] exp_pin(input [4:0] k, input [17:0] s);
      if (k >= 5'h01 && k <= 5'h0c)
         exp_pin = {1'b0, s[k-5'h01]};
      else if (k >= 5'h12 && k <= 5'h16)
         exp_pin = {1'b0, s[k-5'h06]};
      else
         exp_pin = 2'b10;
   endfunction
   initial begin
      #1000000;
      mismatches = mismatches + 1;
      print_verdict;
   end
   initial begin
      {clk, nrst, wr_strobe, one_way, wr_target, wr_index, wr_data} = 0;
      {mismatches, tests_run, want_src} = 0;
      // even pins high, so a wrong pin decode shows on the inputs
      want_pin = 26'h1555555;
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      idle(4);
      chk(map_lock, 32'h0);
      chk(pin_oe_n, 32'h3ffffff);
      chk(periph_in, 32'h0);
      wr(2'h2, 4'h0, 16'h0202);
      idle(5);
      chk(periph_in[1:0], 32'h3);
      for (p = 0; p < 2; p = p + 1) begin
         pat = p ? ~18'h2a5b3 : 18'h2a5b3;
         want_src <= pat;
         for (c = 0; c < 32; c = c + 1) begin
            wr(2'h1, 4'h0, {3'h0, c[4:0], 3'h0, c[4:0]});
            idle(3);
            e = exp_pin(c[4:0], pat);
            chk({pin_oe_n[0], pin_out[0], pin_oe_n[1], pin_out[1]}, {e, e});
         end
      end
      wr(2'h1, 4'h0, 16'h0303);
      lock_seq(8'h40);
      chk(map_lock, 32'h1);
      wr(2'h1, 4'h0, 16'h0000);
      idle(3);
      chk(pin_oe_n[1:0], 32'h0);
      wr(2'h2, 4'h0, 16'h0101);
      idle(5);
      chk(periph_in[1:0], 32'h3);
      wr(2'h0, 4'h0, 16'h0046);
      wr(2'h1, 4'h1, 16'h0000);
      wr(2'h0, 4'h0, 16'h0057);
      wr(2'h0, 4'h0, 16'h0000);
      idle(2);
      chk(map_lock, 32'h1);
      wr(2'h0, 4'h0, 16'h0046);
      lock_seq(8'h00);
      chk(map_lock, 32'h0);
      wr(2'h1, 4'h0, 16'h0000);
      wr(2'h1, 4'h1, 16'h0101);
      idle(3);
      chk(pin_oe_n[3:0], 32'h3);
      chk(mismatch, 32'h0);
      one_way <= 1'b1;
      idle(4);
      lock_seq(8'h40);
      lock_seq(8'h00);
      chk(map_lock, 32'h1);
      nrst <= 1'b0;
      one_way <= 1'b0;
      idle(2);
      nrst <= 1'b1;
      idle(3);
      chk(map_lock, 32'h0);
      chk(pin_oe_n, 32'h3ffffff);
      print_verdict;
   end
endmodule

// ---- rps_pin_map_sva.sv ----
// Purpose: port checks on the pin map
// Assumes: reset spans at least one clock edge
// Notes:   own copy of the output selectors, built from the write port
`timescale 1ns/1ns
module rps_pin_map_sva (
   input wire        CORE_CLK,
   input wire        NRST,
   input wire        WR_STROBE,
   input wire [1:0]  WR_TARGET,
   input wire [3:0]  WR_INDEX,
   input wire [15:0] WR_DATA,
   input wire        ONE_WAY_LOCK_OPTION,
   input wire [25:0] PIN_OUT,
   input wire [25:0] PIN_OE_N,
   input wire        MAP_LOCK,
   input wire        MISMATCH_RESET
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!NRST);
   // ------------------------------------------------------------
   // helper state
   // ------------------------------------------------------------
   reg  [1:0] key;
   reg  [4:0] sel [0:25];
   integer    i;
   wire       key_wr = WR_STROBE && WR_TARGET == 2'h0;
   function ok(input [4:0] c);
      ok = (c >= 5'h01 && c <= 5'h0c) || (c >= 5'h12 && c <= 5'h16);
   endfunction
   always @(posedge CORE_CLK or negedge NRST) begin
      if (!NRST) begin
         key <= 2'h0;
         for (i = 0; i < 26; i = i + 1)
            sel[i] <= 5'h00;
      end else if (WR_STROBE) begin
         // the lock write itself ends the sequence, whatever its value
         key <= (key_wr && key != 2'h2 && WR_DATA[7:0] == 8'h46) ? 2'h1 :
                (key_wr && key == 2'h1 && WR_DATA[7:0] == 8'h57) ? 2'h2 : 2'h0;
         if (WR_TARGET == 2'h1 && WR_INDEX < 4'hd && !MAP_LOCK) begin
            sel[2*WR_INDEX] <= WR_DATA[4:0];
            sel[2*WR_INDEX+1] <= WR_DATA[12:8];
         end
      end
   end
   sequence s_third;
      key_wr && key == 2'h2;
   endsequence
   a_lock_cause: assert property ($changed(MAP_LOCK) |-> $past(key_wr && key == 2'h2))
      else $error("lock moved without full key");
   a_lock_value: assert property (s_third |=> MAP_LOCK ==
      ($past(WR_DATA[6]) | ($past(ONE_WAY_LOCK_OPTION, 3) & $past(MAP_LOCK))))
      else $error("lock value wrong after key");
   a_lock_holds: assert property (WR_STROBE && !(key_wr && key == 2'h2) |=> $stable(MAP_LOCK))
      else $error("lock moved on plain write");
   a_one_way: assert property (ONE_WAY_LOCK_OPTION && $past(ONE_WAY_LOCK_OPTION, 3)
      && $past(MAP_LOCK) |-> MAP_LOCK)
      else $error("one-way lock cleared");
   a_no_mismatch: assert property (!MISMATCH_RESET)
      else $error("mismatch reset in normal use");
   a_locked_write: assert property (WR_STROBE && WR_TARGET == 2'h1 && MAP_LOCK
      && $past(MAP_LOCK) |=> ##1 $stable(PIN_OE_N))
      else $error("locked write changed map");
   genvar j;
   generate
      for (j = 0; j < 26; j = j + 1) begin : g_pin
         a_pin_enable: assert property (PIN_OE_N[j] == !ok($past(sel[j])))
            else $error("pin enable wrong for code");
         a_pin_idle: assert property (PIN_OE_N[j] |-> !PIN_OUT[j])
            else $error("undriven pin not low");
      end
   endgenerate
endmodule
bind rps_pin_map rps_pin_map_sva u_sva (.CORE_CLK(CORE_CLK), .NRST(NRST),
   .WR_STROBE(WR_STROBE), .WR_TARGET(WR_TARGET), .WR_INDEX(WR_INDEX), .WR_DATA(WR_DATA),
   .ONE_WAY_LOCK_OPTION(ONE_WAY_LOCK_OPTION), .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N),
   .MAP_LOCK(MAP_LOCK), .MISMATCH_RESET(MISMATCH_RESET));
